// *** dv/sram_ctrl_model.sv ***
// Memory controller model driving the SRAM port pins.
// Assumes the bench calls cyc once per clock, in order.
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_model (
  input  wire logic  clock,
  input  wire logic  rst,
  input  wire logic  order_cfg,
  output logic [16:0] addr,
  output logic       read_not_write,
  output logic       advance_not_load,
  output logic       select_low_a,
  output logic       select_low_b,
  output logic       select_high,
  output logic       clk_gate_n,
  output logic [3:0] byte_write_n,
  output logic       burst_order_sel,
  output logic       output_drive_n,
  output logic [35:0] data_in
);
  // ****************************************
  // Pin drive
  // ****************************************
  logic wphase = 1'b0;
  // Idle pins at time zero: deselected
  initial begin
    {addr, read_not_write, advance_not_load} = '0;
    {select_low_a, select_low_b, select_high} = 3'b110;
    {clk_gate_n, byte_write_n, output_drive_n, data_in} = '0;
    burst_order_sel = 1'b0;
  end
  // Order select moves only in reset, static after
  always @(posedge clock) if (rst) burst_order_sel <= order_cfg;
  // One command per edge; s flags each select as true
  task automatic cyc(input logic anl, rnw, input logic [2:0] s,
      input logic g, od, input logic [16:0] a,
      input logic [35:0] d, input logic [3:0] m);
    @(posedge clock);
    advance_not_load <= anl;
    read_not_write   <= rnw;
    select_low_a     <= !s[0];
    select_low_b     <= !s[1];
    select_high      <= s[2];
    clk_gate_n       <= g;
    output_drive_n   <= od;
    addr             <= a;
    byte_write_n     <= m;
    // Released bus toggles so no stale word passes
    data_in <= wphase ? d : ~data_in;
    if (!g) wphase = anl ? wphase : (s == 3'b111 && !rnw);
  endtask
endmodule
`default_nettype wire

// *** dv/sram_port_checker_assertions.sv ***
// Checker for the SRAM port pins and the status slave handshake.
// Assumes it is bound onto the port module; one clock, rst async.
`timescale 1ns/1ps
`default_nettype none
module sram_port_checker #(
  parameter int LANES = 4
) (
  input wire logic               clock,
  input wire logic               rst,
  input wire logic               read_not_write,
  input wire logic               advance_not_load,
  input wire logic               select_low_a,
  input wire logic               select_low_b,
  input wire logic               select_high,
  input wire logic               clk_gate_n,
  input wire logic               output_drive_n,
  input wire logic [LANES*9-1:0] data_out,
  input wire logic               data_oe_n,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic               avs_waitrequest
);
  // ****************************************
  // Decoded commands
  // ****************************************
  logic sel, ld, adv, rd, seen_rd_ff;
  assign sel = !select_low_a && !select_low_b && select_high;
  assign ld  = !clk_gate_n && !advance_not_load;
  assign adv = !clk_gate_n && advance_not_load;
  assign rd  = ld && sel && read_not_write;
  // Set by the first read, so power-up floating is checked
  always_ff @(posedge clock or posedge rst) begin
    if (rst) seen_rd_ff <= 1'b0;
    else if (rd) seen_rd_ff <= 1'b1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_desel; ld && !sel |=> data_oe_n; endproperty
  property p_susp;
    clk_gate_n |=> $stable(data_out) && $stable(data_oe_n);
  endproperty
  property p_rd; rd && !output_drive_n |=> !data_oe_n; endproperty
  property p_rd_off; rd && output_drive_n |=> data_oe_n; endproperty
  property p_wr; ld && sel && !read_not_write |=> data_oe_n; endproperty
  property p_noop; (ld && !sel) ##1 adv |=> data_oe_n; endproperty
  property p_burst;
    (rd && !output_drive_n) ##1 (adv && !output_drive_n) |=> !data_oe_n;
  endproperty
  property p_pwr; !seen_rd_ff |-> data_oe_n; endproperty
  // Fixed single wait state on the status slave
  property p_avs;
    (avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_desel: assert property (p_desel) else $error("bus kept");
  a_susp: assert property (p_susp) else $error("gate moved");
  a_rd: assert property (p_rd) else $error("read idle");
  a_rd_off: assert property (p_rd_off) else $error("drive on");
  a_wr: assert property (p_wr) else $error("write drove");
  a_noop: assert property (p_noop) else $error("noop drove");
  a_burst: assert property (p_burst) else $error("burst idle");
  a_pwr: assert property (p_pwr) else $error("early drive");
  a_avs: assert property (p_avs) else $error("wait shape");
  c_burst: cover property (rd ##1 adv ##1 adv);
  c_susp: cover property (!data_oe_n && clk_gate_n);
  c_desel: cover property (ld && !sel);
endmodule
bind zero_turnaround_sram_port sram_port_checker #(.LANES(LANES)) i_chk (
  .clock(clock), .rst(rst), .read_not_write(read_not_write),
  .advance_not_load(advance_not_load), .select_low_a(select_low_a),
  .select_low_b(select_low_b), .select_high(select_high),
  .clk_gate_n(clk_gate_n), .output_drive_n(output_drive_n),
  .data_out(data_out), .data_oe_n(data_oe_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// *** dv/test_zero_turnaround_sram_port.sv ***
// Self-checking bench for the SRAM port and its status slave.
// Assumes the controller model and the checker bind are compiled.
`timescale 1ns/1ps
`default_nettype none
module test_zero_turnaround_sram_port;
  // ****************************************
  // Signals and bookkeeping
  // ****************************************
  localparam logic LO = 1'b0;
  localparam logic HI = 1'b1;
  localparam logic [2:0] ON = 3'b111;
  localparam logic [2:0] OFF = 3'b110;
  localparam logic [35:0] ONE = 36'h0_0000_0001;
  localparam logic [35:0] ZW = 36'h0_0000_0000;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        order_cfg = 1'b0;
  logic [16:0] addr;
  logic        read_not_write, advance_not_load, select_low_a;
  logic        select_low_b, select_high, clk_gate_n, burst_order_sel;
  logic        output_drive_n, data_oe_n, avs_waitrequest;
  logic [3:0]  byte_write_n;
  logic [35:0] data_in, data_out;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, q;
  logic [35:0] shadow [0:31];
  logic [3:0]  rows [8] = '{4'he, 4'hd, 4'hb, 4'h7, 4'ha, 4'h5, 4'hf, 4'h0};
  logic [2:0]  bad [3] = '{3'b110, 3'b101, 3'b011};
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;
  always #10 clock = ~clock;
  sram_ctrl_model i_ctrl (.clock(clock), .rst(rst), .order_cfg(order_cfg),
    .addr(addr), .read_not_write(read_not_write),
    .advance_not_load(advance_not_load), .select_low_a(select_low_a),
    .select_low_b(select_low_b), .select_high(select_high),
    .clk_gate_n(clk_gate_n), .byte_write_n(byte_write_n),
    .burst_order_sel(burst_order_sel), .output_drive_n(output_drive_n),
    .data_in(data_in));
  zero_turnaround_sram_port i_dut (.clock(clock), .rst(rst), .addr(addr),
    .read_not_write(read_not_write), .advance_not_load(advance_not_load),
    .select_low_a(select_low_a), .select_low_b(select_low_b),
    .select_high(select_high), .clk_gate_n(clk_gate_n),
    .byte_write_n(byte_write_n), .burst_order_sel(burst_order_sel),
    .output_drive_n(output_drive_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected word after a lane-masked store
  function automatic logic [35:0] merge(input logic [35:0] o, d,
      input logic [3:0] m);
    for (int l = 0; l < 4; l++) begin
      if (!m[l]) o[8*l+:8] = d[8*l+:8];
      if (!m[l]) o[32+l] = d[32+l];
    end
    return o;
  endfunction
  // Held request until waitrequest is seen low at an edge
  task automatic avs(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= LO;
    avs_write <= LO;
  endtask
  task automatic do_reset(input logic il);
    rst <= HI;
    order_cfg <= il;
    repeat (6) @(posedge clock);
    chk(36'(data_oe_n), ONE);
    chk(36'(avs_waitrequest), ONE);
    rst <= LO;
  endtask
  // Five beats: the fifth shows the wrap to the start word
  task automatic rd_burst(input logic [4:0] s, input logic il);
    logic [1:0] b;
    i_ctrl.cyc(LO, HI, ON, LO, LO, 17'(s), ZW, 4'hf);
    for (int k = 0; k < 5; k++) begin
      b = il ? s[1:0] ^ 2'(k) : s[1:0] + 2'(k);
      i_ctrl.cyc(HI, LO, OFF, LO, LO, 17'h0_0000, ZW, 4'hf);
      #1;
      chk(data_out, shadow[{s[4:2], b}]);
    end
    i_ctrl.cyc(LO, HI, OFF, LO, LO, 17'h0_0000, ZW, 4'hf);
  endtask
  // Hang guard well above the length of the sequence
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      test_done();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    do_reset(LO);
    // Back-to-back full writes seed words 0 to 7
    for (int i = 0; i <= 8; i++) begin
      i_ctrl.cyc(LO, LO, i < 8 ? ON : OFF, LO, LO, 17'(i),
        36'h5_a5a5_0000 ^ 36'(i - 1), 4'h0);
      if (i > 0) shadow[i - 1] = 36'h5_a5a5_0000 ^ 36'(i - 1);
    end
    // Row table: word i gets lane mask rows[i]
    foreach (rows[i]) begin
      i_ctrl.cyc(LO, LO, ON, LO, LO, 17'(i), ZW, 4'h0);
      i_ctrl.cyc(LO, LO, OFF, LO, LO, 17'h0_0000, 36'ha_cafe_f00d, rows[i]);
      shadow[i] = merge(shadow[i], 36'ha_cafe_f00d, rows[i]);
    end
    for (int i = 0; i <= 8; i++) begin
      i_ctrl.cyc(LO, HI, i < 8 ? ON : OFF, LO, LO, 17'(i), ZW, 4'hf);
      #1;
      if (i > 0) chk(data_out, shadow[i - 1]);
    end
    // Linear write burst from 17 with the direction pin flipped
    for (int k = 0; k <= 5; k++) begin
      i_ctrl.cyc(k > 0 && k < 5, k > 0, k > 0 ? OFF : ON, LO, LO,
        17'h0_0011, 36'h3_0000_0000 | 36'(k - 1), 4'h0);
      if (k > 0) shadow[16 + k % 4] = 36'h3_0000_0000 | 36'(k - 1);
    end
    rd_burst(5'h11, LO);
    // Gated edges hold the read word and ignore a load
    i_ctrl.cyc(LO, HI, ON, LO, LO, 17'h0_0003, ZW, 4'hf);
    i_ctrl.cyc(LO, HI, ON, HI, LO, 17'h0_0005, ZW, 4'hf);
    i_ctrl.cyc(LO, HI, ON, HI, LO, 17'h0_0005, ZW, 4'hf);
    #1;
    chk(data_out, shadow[3]);
    i_ctrl.cyc(LO, HI, OFF, LO, LO, 17'h0_0005, ZW, 4'hf);
    #1;
    chk(data_out, shadow[3]);
    // Each select false in turn ends the access
    foreach (bad[j]) begin
      i_ctrl.cyc(LO, HI, ON, LO, LO, 17'h0_0002, ZW, 4'hf);
      i_ctrl.cyc(LO, HI, bad[j], LO, LO, 17'h0_0004, ZW, 4'hf);
      #1;
      chk(data_out, shadow[2]);
      i_ctrl.cyc(HI, HI, ON, LO, LO, 17'h0_0004, ZW, 4'hf);
      #1;
      chk(36'(data_oe_n), ONE);
      i_ctrl.cyc(HI, HI, ON, LO, LO, 17'h0_0004, ZW, 4'hf);
      #1;
      chk(36'(data_oe_n), ONE);
    end
    i_ctrl.cyc(LO, HI, ON, LO, HI, 17'h0_0001, ZW, 4'hf);
    i_ctrl.cyc(HI, HI, OFF, LO, HI, 17'h0_0001, ZW, 4'hf);
    #1;
    chk(36'(data_oe_n), ONE);
    // Status slave: unmapped read, stray write, order bit
    avs(LO, 4'h2, 32'h0000_0000, q);
    chk(36'(q), ZW);
    avs(HI, 4'h2, 32'hffff_ffff, q);
    avs(LO, sram_port_pkg::STATUS_OFFSET, 32'h0000_0000, q);
    chk(36'(q[sram_port_pkg::STAT_ORDER_BIT]), ZW);
    // Locked port: data phase neither stores nor bypasses
    avs(HI, sram_port_pkg::CTRL_OFFSET, 32'h0000_0001, q);
    i_ctrl.cyc(LO, LO, ON, LO, LO, 17'h0_0000, ZW, 4'hf);
    i_ctrl.cyc(LO, HI, ON, LO, LO, 17'h0_0000, ZW, 4'h0);
    i_ctrl.cyc(HI, HI, OFF, LO, LO, 17'h0_0000, ZW, 4'hf);
    #1;
    chk(data_out, shadow[0]);
    do_reset(HI);
    rd_burst(5'h12, HI);
    avs(LO, sram_port_pkg::STATUS_OFFSET, 32'h0000_0000, q);
    chk(36'(q[sram_port_pkg::STAT_ORDER_BIT]), ONE);
    test_done();
  end
endmodule
`default_nettype wire

// *** logic/sram_cell_array.sv ***
// Storage array with per-bit write mask and asynchronous read.
// Assumes the caller qualifies the write enable with any suspend.
`timescale 1ns/1ps
`default_nettype none

module sram_cell_array #(
  parameter int ADDR_W = 17,
  parameter int WORD_W = 36
) (
  input  wire logic              clock,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [WORD_W-1:0] wr_data,
  input  wire logic [WORD_W-1:0] wr_mask,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [WORD_W-1:0] rd_data
);

  // ****************************************************************
  // Array
  // ****************************************************************
  // No reset: contents are undefined until written, as in real cells
  logic [WORD_W-1:0] cells [0:(1<<ADDR_W)-1];

  // Masked write, untouched bits keep their old value
  always_ff @(posedge clock) begin
    if (wr_en) begin
      cells[wr_addr] <= (cells[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  // Flow-through read
  assign rd_data = cells[rd_addr];

endmodule

`default_nettype wire

// *** logic/sram_port_pkg.sv ***
// Shared constants for the zero-wait synchronous SRAM port model.
// Assumes one clock domain and a byte-addressed Avalon-MM register slave.
package sram_port_pkg;

  // ****************************************************************
  // Array geometry defaults
  // ****************************************************************
  localparam int ADDR_W_DEF = 17;
  localparam int LANES_DEF  = 4;
  localparam int BYTE_W     = 8;
  localparam int BEAT_W     = 2;

  // ****************************************************************
  // Register map, byte addresses on a 32-bit data bus
  // ****************************************************************
  localparam int          CSR_ADDR_W    = 4;
  localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET = 4'h4;
  localparam logic [3:0]  ADDR_OFFSET   = 4'h8;
  localparam logic [3:0]  COUNT_OFFSET  = 4'hC;

  // Field positions
  localparam int CTRL_LOCK_BIT   = 0;
  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_BEAT_LSB   = 2;
  localparam int STAT_WRPEND_BIT = 4;
  localparam int STAT_DRIVE_BIT  = 5;
  localparam int STAT_ORDER_BIT  = 6;
  localparam int COUNT_WR_LSB    = 16;
  localparam int COUNT_W         = 16;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic        LOCK_RST  = 1'b0;
  localparam logic        OE_N_RST  = 1'b1;
  localparam logic        WAIT_RST  = 1'b1;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [1:0]  BEAT_RST  = 2'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ****************************************************************
  // Port sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } port_state_t;

endpackage

// *** logic/zero_turnaround_sram_port.sv ***
// Synchronous SRAM port: load/burst/deselect/noop/suspend sequencing,
// byte-lane writes and a small Avalon-MM status and control slave.
// Assumes the controller drives all pins from this same clock.
//
// Functional notes
// (RULE1) Advance high increments burst counter
// (RULE2) Direction input ignored while advancing
// (RULE3) Burst direction fixed at load
// (RULE4) Load with any select false deselects
// (RULE5) Bus floats cycle after deselect
// (RULE6) Gate high makes edge absent
// (RULE7) Suspend holds registers and driven data
// (RULE8) Selected needs all three selects true
// (RULE9) Data outputs float from power up
// (RULE10) Each lane writes one byte plus parity
// (RULE11) Any lane combination writes together
// (RULE12) Order select high: interleaved XOR order
// (RULE13) Order select low: linear modulo four
// (RULE14) Counter wraps after fourth beat
// (RULE15) Sampled on rising edge, flow-through data
// (RULE16) Load read drives word next cycle
// (RULE17) Output drive high keeps pins floating
// (RULE18) Controller holds order select static
// (RULE19) Load write takes data next cycle
// (RULE20) Advance after deselect/noop is noop
// (RULE21) All lanes off: write without storing
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module zero_turnaround_sram_port #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W_DEF,
  parameter int LANES  = sram_port_pkg::LANES_DEF
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic [ADDR_W-1:0]        addr,
  input  wire logic                     read_not_write,
  input  wire logic                     advance_not_load,
  input  wire logic                     select_low_a,
  input  wire logic                     select_low_b,
  input  wire logic                     select_high,
  input  wire logic                     clk_gate_n,
  input  wire logic [LANES-1:0]         byte_write_n,
  input  wire logic                     burst_order_sel,
  input  wire logic                     output_drive_n,
  input  wire logic [LANES*9-1:0]       data_in,
  output logic      [LANES*9-1:0]       data_out,
  output logic                          data_oe_n,
  input  wire logic [sram_port_pkg::CSR_ADDR_W-1:0] avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest
);

  localparam int WORD_W = LANES * 9;
  localparam int BYTES  = LANES * sram_port_pkg::BYTE_W;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The burst counter is two bits wide, so the base needs two bits
  if (ADDR_W < 2 || ADDR_W > 24) begin : g_bad_addr
    $error("ADDR_W must lie between 2 and 24");
  end
  // Parity bits sit above the data bytes, one per lane
  if (LANES < 1 || LANES > 4) begin : g_bad_lanes
    $error("LANES must lie between 1 and 4");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    sram_port_pkg::port_state_t state;
    logic [ADDR_W-1:0]          base;
    logic [1:0]                 beat;
    logic                       wr_pend;
    logic [ADDR_W-1:0]          wr_addr;
    logic [WORD_W-1:0]          dout;
    logic                       oe_n;

    logic                       lock;
    logic [15:0]                rd_cnt;
    logic [15:0]                wr_cnt;
    logic                       wait_req;
    logic [31:0]                rdata;
  } port_regs_t;

  // Current state and its next value
  port_regs_t st_ff;
  port_regs_t nxt_st;

  // ****************************************************************
  // Lane masks and storage
  // ****************************************************************
  logic [WORD_W-1:0] lane_mask;
  logic [WORD_W-1:0] mem_rd_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [WORD_W-1:0] rd_word;

  logic              mem_wr_en;
  logic              suspend;
  logic              selected;

  // One lane gates eight data bits and its own parity bit
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lane_mask[i*8 +: 8]   = {8{~byte_write_n[i]}};   // [RULE10]
    assign lane_mask[BYTES + i]  = ~byte_write_n[i];        // [RULE10]
  end

  // Edge blocked while the clock gate is high
  assign suspend  = clk_gate_n;                              // [RULE6]
  // Deselected when any one select is false
  assign selected = ~select_low_a & ~select_low_b & select_high; // [RULE8]

  // Data phase write; lanes all off still completes as a write slot
  assign mem_wr_en = st_ff.wr_pend & ~suspend & ~st_ff.lock; // [RULE11]

  sram_cell_array #(
    .ADDR_W (ADDR_W),
    .WORD_W (WORD_W)
  ) u_cells (
    .clock   (clock),
    .wr_en   (mem_wr_en),
    .wr_addr (st_ff.wr_addr),
    .wr_data (data_in),
    .wr_mask (lane_mask),
    .rd_addr (rd_addr),
    .rd_data (mem_rd_data)
  );

  // ****************************************************************
  // Burst address arithmetic
  // ****************************************************************
  // Low two bits of a beat; only the low bits ever move
  function automatic logic [1:0] burst_low(
    input logic [1:0] start,
    input logic [1:0] beat,
    input logic       interleave
  );
    logic [1:0] low;
    low = 2'b00;
    if (interleave) begin
      low = start ^ beat;                                    // [RULE12]
    end else begin
      low = start + beat;                                    // [RULE13]
    end
    return low;
  endfunction

  logic [1:0]        nxt_beat;
  logic [ADDR_W-1:0] burst_addr;
  logic              advancing;

  // Two-bit count wraps from the fourth beat back to the first
  assign nxt_beat   = st_ff.beat + 2'b01;                    // [RULE14]

  assign burst_addr = {st_ff.base[ADDR_W-1:2],
                       burst_low(st_ff.base[1:0], nxt_beat,
                                 burst_order_sel)};
  assign advancing  = advance_not_load;                      // [RULE1]

  // Read source: external address on load, counter on advance
  assign rd_addr = advancing ? burst_addr : addr;

  // Bypass the data phase write that lands on this same edge
  always_comb begin
    rd_word = mem_rd_data;
    if (mem_wr_en && st_ff.wr_addr == rd_addr) begin
      rd_word = (mem_rd_data & ~lane_mask) | (data_in & lane_mask);
    end
  end

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  logic        bus_req;
  logic        bus_take;

  logic [31:0] status_word;
  logic [31:0] addr_word;
  logic [31:0] count_word;
  logic [31:0] read_mux;

  // One wait cycle: the answer edge is the one with waitrequest low
  assign bus_req  = avs_read | avs_write;
  assign bus_take = bus_req & ~st_ff.wait_req;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[sram_port_pkg::STAT_STATE_LSB +: 2] = st_ff.state;
    status_word[sram_port_pkg::STAT_BEAT_LSB +: 2]  = st_ff.beat;
    status_word[sram_port_pkg::STAT_WRPEND_BIT]     = st_ff.wr_pend;
    status_word[sram_port_pkg::STAT_DRIVE_BIT]      = ~st_ff.oe_n;
    status_word[sram_port_pkg::STAT_ORDER_BIT]      = burst_order_sel;

    addr_word = 32'h0000_0000;
    addr_word[ADDR_W-1:0] = st_ff.base;

    count_word = {st_ff.wr_cnt, st_ff.rd_cnt};
  end

  // Unmapped offsets read as zero
  always_comb begin
    case (avs_address)
      sram_port_pkg::CTRL_OFFSET: begin
        read_mux = {31'h0000_0000, st_ff.lock};
      end

      sram_port_pkg::STATUS_OFFSET: begin
        read_mux = status_word;
      end

      sram_port_pkg::ADDR_OFFSET: begin
        read_mux = addr_word;
      end

      sram_port_pkg::COUNT_OFFSET: begin
        read_mux = count_word;
      end

      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;

    // Bus slave keeps running while the memory port is suspended
    nxt_st.wait_req = ~(bus_req & st_ff.wait_req);

    if (bus_req && st_ff.wait_req) begin
      nxt_st.rdata = read_mux;
    end

    // Lock bit changes only on the answer edge
    if (bus_take && avs_write && avs_byteenable[0] &&
        avs_address == sram_port_pkg::CTRL_OFFSET) begin
      nxt_st.lock = avs_writedata[sram_port_pkg::CTRL_LOCK_BIT];
    end

    // Memory port: a gated edge changes nothing at all
    if (!suspend) begin                                      // [RULE6] [RULE7]
      // Last cycle's write completes on this edge for any command unless the port is locked
      nxt_st.wr_pend = 1'b0;                                 // [RULE19]
      nxt_st.oe_n    = 1'b1;

      if (!advancing) begin
        if (!selected) begin
          // Deselect or stop: burst ends, bus floats next cycle
          nxt_st.state = sram_port_pkg::ST_IDLE;             // [RULE4] [RULE5]
          nxt_st.beat  = sram_port_pkg::BEAT_RST;
        end else if (read_not_write) begin
          // Load read; direction held for the whole burst
          nxt_st.state = sram_port_pkg::ST_READ;             // [RULE3]
          nxt_st.base  = addr;
          nxt_st.beat  = sram_port_pkg::BEAT_RST;
          nxt_st.dout  = rd_word;                            // [RULE16] [RULE15]
          nxt_st.oe_n  = output_drive_n;                     // [RULE17]
          nxt_st.rd_cnt = st_ff.rd_cnt + 16'h0001;
        end else begin
          // Load write; data and lanes arrive next cycle
          nxt_st.state   = sram_port_pkg::ST_WRITE;          // [RULE3]
          nxt_st.base    = addr;
          nxt_st.beat    = sram_port_pkg::BEAT_RST;
          nxt_st.wr_pend = 1'b1;                             // [RULE19]
          nxt_st.wr_addr = addr;
          nxt_st.wr_cnt  = st_ff.wr_cnt + 16'h0001;          // [RULE21]
        end
      end else begin
        // Advance: direction input not looked at here
        case (st_ff.state)                                   // [RULE2]
          sram_port_pkg::ST_READ: begin
            nxt_st.beat   = nxt_beat;                        // [RULE1] [RULE14]
            nxt_st.dout   = rd_word;
            nxt_st.oe_n   = output_drive_n;                  // [RULE17]
            nxt_st.rd_cnt = st_ff.rd_cnt + 16'h0001;
          end

          sram_port_pkg::ST_WRITE: begin
            nxt_st.beat    = nxt_beat;                       // [RULE1] [RULE14]
            nxt_st.wr_pend = 1'b1;
            nxt_st.wr_addr = burst_addr;
            nxt_st.wr_cnt  = st_ff.wr_cnt + 16'h0001;        // [RULE21]
          end

          sram_port_pkg::ST_IDLE: begin
            nxt_st.state = sram_port_pkg::ST_IDLE;           // [RULE20]
          end

          default: begin
            nxt_st.state = sram_port_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Output enable resets inactive so the pins float from power up
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff.state    <= sram_port_pkg::ST_IDLE;
      st_ff.base     <= '0;
      st_ff.beat     <= sram_port_pkg::BEAT_RST;
      st_ff.wr_pend  <= 1'b0;
      st_ff.wr_addr  <= '0;
      st_ff.dout     <= '0;
      st_ff.oe_n     <= sram_port_pkg::OE_N_RST;             // [RULE9]

      st_ff.lock     <= sram_port_pkg::LOCK_RST;
      st_ff.rd_cnt   <= sram_port_pkg::COUNT_RST;
      st_ff.wr_cnt   <= sram_port_pkg::COUNT_RST;
      st_ff.wait_req <= sram_port_pkg::WAIT_RST;
      st_ff.rdata    <= sram_port_pkg::RDATA_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs, each straight from a flip-flop
  // ****************************************************************
  assign data_out        = st_ff.dout;
  assign data_oe_n       = st_ff.oe_n;
  assign avs_readdata    = st_ff.rdata;
  assign avs_waitrequest = st_ff.wait_req;

endmodule

`default_nettype wire
